/* rtcal_pkg.sv */
// Constants and state type of the alarm and time-keeping register block
package rtcal_pkg;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 4;
	localparam int HALF_SEC_MS = 500;
	localparam int HALF_SEC_CYCLES = (HALF_SEC_MS * 1000000) / CLK_PERIOD_NS;
	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_ALCFG = 8'h00;
	localparam logic [7:0] OFS_WKHR = 8'h04;
	localparam logic [7:0] OFS_MINUTES_SECONDS_VALUE = 8'h08;
	localparam logic [7:0] OFS_AVAL = 8'h0C;
	localparam logic [7:0] OFS_CTRL = 8'h10;
	localparam logic [7:0] OFS_STS = 8'h14;
	localparam logic [7:0] OFS_CLR = 8'h18;
	localparam logic [7:0] OFS_IEN = 8'h1C;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int ALCFG_ON_BIT = 15;
	localparam int ALCFG_CHIME_BIT = 14;
	localparam int ALCFG_MASK_LSB = 10;
	localparam int ALCFG_PTR_LSB = 8;
	localparam int WEEKDAY_DIGIT_LSB = 8;
	localparam int HRT_LSB = 4;
	localparam int MINT_LSB = 12;
	localparam int MINO_LSB = 8;
	localparam int SECT_LSB = 4;
	localparam int STS_ALARM_BIT = 0;
	localparam int STS_SEC_BIT = 1;
	// ----------------------------------------
	// Digit limits, counter ends, interval codes
	// ----------------------------------------
	localparam logic [2:0] WEEKDAY_DIGIT_MAX = 3'h6;
	localparam logic [1:0] HRT_MAX = 2'h2;
	localparam logic [3:0] ONES_MAX = 4'h9;
	localparam logic [2:0] TENS_MAX = 3'h5;
	localparam logic [3:0] HRO_LAST = 4'h3;
	localparam logic [7:0] RPT_FULL = 8'hFF;
	localparam logic [3:0] AM_HALF = 4'h0;
	localparam logic [3:0] AM_SEC = 4'h1;
	localparam logic [3:0] AM_10SEC = 4'h2;
	localparam logic [3:0] AM_MIN = 4'h3;
	localparam logic [3:0] AM_10MIN = 4'h4;
	localparam logic [3:0] AM_HOUR = 4'h5;
	localparam logic [3:0] AM_DAY = 4'h6;
	localparam logic [3:0] AM_WEEK = 4'h7;
	localparam logic [3:0] AM_MONTH = 4'h8;
	localparam logic [3:0] AM_YEAR = 4'h9;
	// ----------------------------------------
	// Whole state of the block
	// ----------------------------------------
	typedef struct packed {
		logic [26:0] div;
		logic phase;
		logic alarm_on;
		logic chime;
		logic [3:0] mask;
		logic [1:0] ptr;
		logic [7:0] rpt;
		logic [2:0] weekday_digit;
		logic [1:0] hrt;
		logic [3:0] hro;
		logic [2:0] mint;
		logic [3:0] mino;
		logic [2:0] sect;
		logic [3:0] seco;
		logic [2:0][15:0] aval;
		logic unlock;
		logic [1:0] sts;
		logic [1:0] ien;
		logic rdy;
		logic err;
		logic [31:0] rdata;
		logic irq;
	} rtcal_state_t;
endpackage : rtcal_pkg

/* rtcal_top.sv */
// Alarm configuration, BCD time registers and APB slave of the clock block
//
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Weekday digit only holds zero to six
// - Hours tens digit zero to two, except counting on from written hours 24 to 29 reaches three
// - Hours ones digit only zero to nine
// - Minutes tens digit only zero to five
// - Minutes ones digit only zero to nine
// - Seconds tens digit only zero to five
// - Seconds ones digit only zero to nine
// - Weekday/hours writes need write unlock set
// - Chime wraps repeat counter, else stops
// - Interval mask picks alarm period; reserved codes
// - Unimplemented bits read zero, ignore writes
module rtcal_top #(
	parameter int HALF_SEC_CYCLES = rtcal_pkg::HALF_SEC_CYCLES
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq
);
	rtcal_pkg::rtcal_state_t q;
	rtcal_pkg::rtcal_state_t n;
	logic tick;
	logic sec_tick;
	logic hit;
	logic done;
	logic wr;
	logic match;
	logic alarm_ev;
	logic [15:0] wk_word;
	logic [15:0] ms_word;
	logic [15:0] cfg_word;
	logic [15:0] win_word;
	logic [31:0] rd;
	logic [1:0] clr;

	// ----------------------------------------
	// Read views and decode
	// ----------------------------------------
	// Unimplemented positions are constant zero in every view
	always_comb begin
		cfg_word = {q.alarm_on, q.chime, q.mask, q.ptr, q.rpt};
		wk_word = {5'h00, q.weekday_digit, 2'h0, q.hrt, q.hro};
		ms_word = {1'b0, q.mint, q.mino, 1'b0, q.sect, q.seco};
		win_word = (q.ptr == 2'h3) ? 16'h0000 : q.aval[q.ptr];
		hit = 1'b1;
		rd = 32'h0000_0000;
		case (paddr)
			rtcal_pkg::OFS_ALCFG: rd = {16'h0000, cfg_word};
			rtcal_pkg::OFS_WKHR: rd = {16'h0000, wk_word};
			rtcal_pkg::OFS_MINUTES_SECONDS_VALUE: rd = {16'h0000, ms_word};
			rtcal_pkg::OFS_AVAL: rd = {16'h0000, win_word};
			rtcal_pkg::OFS_CTRL: rd = {31'h0000_0000, q.unlock};
			rtcal_pkg::OFS_STS: rd = {30'h0000_0000, q.sts};
			rtcal_pkg::OFS_CLR: rd = 32'h0000_0000;
			rtcal_pkg::OFS_IEN: rd = {30'h0000_0000, q.ien};
			default: hit = 1'b0;
		endcase
		done = psel & penable & q.rdy;
		wr = done & pwrite & hit;
	end

	// ----------------------------------------
	// Time base and alarm comparison
	// ----------------------------------------
	// Interval codes compare ever more digits; date codes fall back to weekday
	always_comb begin
		tick = (q.div == 27'(HALF_SEC_CYCLES - 1));
		sec_tick = tick & q.phase;
		case (q.mask)
			rtcal_pkg::AM_HALF: match = tick;
			rtcal_pkg::AM_SEC: match = sec_tick;
			rtcal_pkg::AM_10SEC: match = sec_tick & (q.seco == q.aval[0][3:0]);
			rtcal_pkg::AM_MIN: match = sec_tick & ({1'b0, q.sect, q.seco} == q.aval[0][7:0]);
			rtcal_pkg::AM_10MIN: match = sec_tick & (ms_word[11:0] == q.aval[0][11:0]);
			rtcal_pkg::AM_HOUR: match = sec_tick & (ms_word == q.aval[0]);
			rtcal_pkg::AM_DAY: match = sec_tick & (ms_word == q.aval[0])
				& (wk_word[7:0] == q.aval[1][7:0]);
			rtcal_pkg::AM_WEEK, rtcal_pkg::AM_MONTH, rtcal_pkg::AM_YEAR:
				match = sec_tick & (ms_word == q.aval[0]) & (wk_word == q.aval[1]);
			default: match = 1'b0;
		endcase
		alarm_ev = q.alarm_on & match;
		clr = (wr && paddr == rtcal_pkg::OFS_CLR) ? pwdata[1:0] : 2'h0;
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		n = q;
		n.rdy = 1'b0;
		n.err = 1'b0; // Error flag lives only beside its pready pulse
		// Divider gives the half-second enable pulse
		n.div = tick ? 27'h000_0000 : q.div + 27'h000_0001;
		if (tick) begin
			n.phase = ~q.phase;
		end
		// BCD chain, each digit wraps at its own limit
		if (sec_tick) begin
			n.seco = q.seco + 4'h1;
			if (q.seco == rtcal_pkg::ONES_MAX) begin
				n.seco = 4'h0;
				n.sect = q.sect + 3'h1;
				if (q.sect == rtcal_pkg::TENS_MAX) begin
					n.sect = 3'h0;
					n.mino = q.mino + 4'h1;
					if (q.mino == rtcal_pkg::ONES_MAX) begin
						n.mino = 4'h0;
						n.mint = q.mint + 3'h1;
						if (q.mint == rtcal_pkg::TENS_MAX) begin
							n.mint = 3'h0;
							n.hro = q.hro + 4'h1;
							if (q.hrt == rtcal_pkg::HRT_MAX && q.hro == rtcal_pkg::HRO_LAST) begin
								n.hro = 4'h0;
								n.hrt = 2'h0;
								n.weekday_digit = (q.weekday_digit == rtcal_pkg::WEEKDAY_DIGIT_MAX) ? 3'h0
									: q.weekday_digit + 3'h1;
							end else if (q.hro == rtcal_pkg::ONES_MAX) begin
								n.hro = 4'h0;
								n.hrt = q.hrt + 2'h1;
							end
						end
					end
				end
			end
		end
		// Alarm event: count down, wrap only with chime, stop otherwise
		if (alarm_ev) begin
			if (q.rpt != 8'h00) begin
				n.rpt = q.rpt - 8'h01;
			end else if (q.chime) begin
				n.rpt = rtcal_pkg::RPT_FULL;
			end else begin
				n.alarm_on = 1'b0;
			end
		end
		// Access phase: answer one cycle after penable rises
		if (psel && penable && !q.rdy) begin
			n.rdy = 1'b1;
			n.err = ~hit;
			n.rdata = (hit && !pwrite) ? rd : 32'h0000_0000;
		end
		// Window reads, and writes with pstrb[1], walk the pointer down to zero
		if (done && hit && paddr == rtcal_pkg::OFS_AVAL && q.ptr != 2'h0) begin
			if (!pwrite || pstrb[1]) begin
				n.ptr = q.ptr - 2'h1;
			end
		end
		// Software writes land at the completing edge and win over counting
		if (wr) begin
			case (paddr)
				rtcal_pkg::OFS_ALCFG: begin
					if (pstrb[1]) begin
						n.alarm_on = pwdata[rtcal_pkg::ALCFG_ON_BIT];
						n.chime = pwdata[rtcal_pkg::ALCFG_CHIME_BIT];
						n.mask = pwdata[rtcal_pkg::ALCFG_MASK_LSB +: 4];
						n.ptr = pwdata[rtcal_pkg::ALCFG_PTR_LSB +: 2];
					end
					if (pstrb[0]) begin
						n.rpt = pwdata[7:0];
					end
				end
				rtcal_pkg::OFS_WKHR: begin
					// Locked writes vanish; out of range digits load zero
					if (q.unlock && pstrb[1]) begin
						n.weekday_digit = (pwdata[rtcal_pkg::WEEKDAY_DIGIT_LSB +: 3] > rtcal_pkg::WEEKDAY_DIGIT_MAX)
							? 3'h0 : pwdata[rtcal_pkg::WEEKDAY_DIGIT_LSB +: 3];
					end
					if (q.unlock && pstrb[0]) begin
						n.hrt = (pwdata[rtcal_pkg::HRT_LSB +: 2] > rtcal_pkg::HRT_MAX)
							? 2'h0 : pwdata[rtcal_pkg::HRT_LSB +: 2];
						n.hro = (pwdata[3:0] > rtcal_pkg::ONES_MAX) ? 4'h0 : pwdata[3:0];
					end
				end
				rtcal_pkg::OFS_MINUTES_SECONDS_VALUE: begin
					if (q.unlock && pstrb[1]) begin
						n.mint = (pwdata[rtcal_pkg::MINT_LSB +: 3] > rtcal_pkg::TENS_MAX)
							? 3'h0 : pwdata[rtcal_pkg::MINT_LSB +: 3];
						n.mino = (pwdata[rtcal_pkg::MINO_LSB +: 4] > rtcal_pkg::ONES_MAX)
							? 4'h0 : pwdata[rtcal_pkg::MINO_LSB +: 4];
					end
					if (q.unlock && pstrb[0]) begin
						n.sect = (pwdata[rtcal_pkg::SECT_LSB +: 3] > rtcal_pkg::TENS_MAX)
							? 3'h0 : pwdata[rtcal_pkg::SECT_LSB +: 3];
						n.seco = (pwdata[3:0] > rtcal_pkg::ONES_MAX) ? 4'h0 : pwdata[3:0];
					end
				end
				rtcal_pkg::OFS_AVAL: begin
					if (q.ptr != 2'h3) begin
						if (pstrb[1]) begin
							n.aval[q.ptr][15:8] = pwdata[15:8];
						end
						if (pstrb[0]) begin
							n.aval[q.ptr][7:0] = pwdata[7:0];
						end
					end
				end
				rtcal_pkg::OFS_CTRL: begin
					if (pstrb[0]) begin
						n.unlock = pwdata[0];
					end
				end
				rtcal_pkg::OFS_IEN: begin
					if (pstrb[0]) begin
						n.ien = pwdata[1:0];
					end
				end
				default: n.unlock = q.unlock;
			endcase
		end
		// Sticky flags: a new event beats a clear in the same cycle
		n.sts = (q.sts & ~clr)
			| {sec_tick, alarm_ev};
		n.irq = |(n.sts & n.ien);
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign prdata = q.rdata;
	assign pready = q.rdy;
	assign pslverr = q.err;
	assign irq = q.irq;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	weekday_digit_range_a: assert property (q.weekday_digit <= rtcal_pkg::WEEKDAY_DIGIT_MAX)
		else $error("weekday digit out of range");
	hrt_range_a: assert property (q.hrt <= rtcal_pkg::HRT_MAX)
		else $error("hours tens out of range");
	hro_range_a: assert property (q.hro <= rtcal_pkg::ONES_MAX)
		else $error("hours ones out of range");
	mint_range_a: assert property (q.mint <= rtcal_pkg::TENS_MAX)
		else $error("minutes tens out of range");
	mino_range_a: assert property (q.mino <= rtcal_pkg::ONES_MAX)
		else $error("minutes ones out of range");
	sect_range_a: assert property (q.sect <= rtcal_pkg::TENS_MAX)
		else $error("seconds tens out of range");
	seco_range_a: assert property (q.seco <= rtcal_pkg::ONES_MAX)
		else $error("seconds ones out of range");
	locked_write_a: assert property (wr && paddr == rtcal_pkg::OFS_WKHR && !q.unlock
		&& !sec_tick |=> $stable(wk_word))
		else $error("locked weekday/hours write changed value");
	rpt_wrap_a: assert property (alarm_ev && q.rpt == 8'h00 && q.chime && !wr
		|=> q.rpt == rtcal_pkg::RPT_FULL)
		else $error("repeat counter did not wrap");
	alarm_off_a: assert property (alarm_ev && q.rpt == 8'h00 && !q.chime && !wr
		|=> !q.alarm_on && q.rpt == 8'h00)
		else $error("alarm not disabled at end of repeats");
	reserved_mask_a: assert property (q.mask > rtcal_pkg::AM_YEAR |-> !alarm_ev)
		else $error("reserved interval produced alarm");
	rd_upper_zero_a: assert property (pready && !pslverr |-> prdata[31:16] == 16'h0000)
		else $error("upper read bits not zero");
	ptr_dec_a: assert property (done && !pwrite && paddr == rtcal_pkg::OFS_AVAL
		&& q.ptr != 2'h0 |=> q.ptr == $past(q.ptr) - 2'h1)
		else $error("window pointer did not decrement");
	answer_time_a: assert property ($rose(psel & penable) |-> ##1 pready)
		else $error("pready not one cycle after penable");

	alarm_fire_c: cover property (alarm_ev);
	chime_wrap_c: cover property (alarm_ev && q.chime && q.rpt == 8'h00);
	locked_write_c: cover property (wr && paddr == rtcal_pkg::OFS_WKHR && !q.unlock);
	bad_addr_c: cover property (pready && pslverr);
endmodule : rtcal_top
`default_nettype wire

/* rtcal_top_tb_top.sv */
// Self-checking bench for the alarm and time register block over APB
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin error_cnt++; \
	$display("ERROR %0t: got %h exp %h", $time, (got), (exp)); end end
module rtcal_top_tb_top;
	// ----------------------------------------
	// Signals and design under test
	// ----------------------------------------
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'hF;
	logic [31:0] prdata;
	logic pready, pslverr, irq;
	int error_cnt = 0;
	int tests_run = 0;
	logic [31:0] r;
	logic e;
	// Short half second keeps every alarm wait within 160 cycles
	rtcal_top #(.HALF_SEC_CYCLES(8)) rtcal_top_i (.clk_sys(clk_sys), .reset(reset),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
	always #2 clk_sys = ~clk_sys;
	// ----------------------------------------
	// Bus tasks
	// ----------------------------------------
	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : wrap_up
	// Request held until pready is seen high at an edge, never assumed
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 50);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			error_cnt++;
			$display("ERROR %0t: no pready", $time);
			wrap_up();
		end
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
		apb(1'b0, a, 32'h0);
		`CHK(r & m, exp)
	endtask : rd
	// Two edges first so a just-cleared status no longer shows on irq
	task automatic wait_irq();
		int n;
		n = 0;
		repeat (2) @(posedge clk_sys);
		while (irq !== 1'b1) begin
			@(posedge clk_sys);
			n++;
			if (n > 200) begin
				error_cnt++;
				$display("ERROR %0t: irq timeout", $time);
				wrap_up();
			end
		end
	endtask : wait_irq
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge clk_sys);
		reset <= 1'b0;
		rd(8'h00, 32'h0, 32'hFFFF_FFFF);
		wr(8'h04, 32'h0123);
		rd(8'h04, 32'h0, 32'hFFFF_FFFF);
		$display("test lock done");
		wr(8'h10, 32'h1);
		wr(8'h04, 32'hFEE3);
		rd(8'h04, 32'h0623, 32'hFFFF_FFFF);
		wr(8'h04, 32'h073A);
		rd(8'h04, 32'h0, 32'hFFFF_FFFF);
		wr(8'h08, 32'h7F7F);
		rd(8'h08, 32'h0, 32'hFFFE);
		wr(8'h08, 32'hD9D0);
		rd(8'h08, 32'h5950, 32'hFFFE);
		apb(1'b0, 8'h20, 32'h0);
		`CHK({e, r}, {1'b1, 32'h0})
		$display("test time registers done");
		// Alarm countdown without chime, then roll-over with chime
		wr(8'h1C, 32'h1);
		wr(8'h00, 32'h0);
		wr(8'h18, 32'h3);
		wr(8'h00, 32'h8001);
		wait_irq();
		rd(8'h00, 32'h8000, 32'hFFFF);
		// The last event landing just after the clear would set the status again, so let that event pass first
		repeat (16) @(posedge clk_sys);
		rd(8'h00, 32'h0, 32'hFFFF);
		rd(8'h14, 32'h1, 32'h1);
		`CHK(irq, 1'b1)
		wr(8'h18, 32'h1);
		rd(8'h14, 32'h0, 32'h1);
		wr(8'h00, 32'hC000);
		wait_irq();
		rd(8'h00, 32'hC0FF, 32'hFFFF);
		wr(8'h1C, 32'h0);
		wr(8'h18, 32'h1);
		repeat (24) @(posedge clk_sys);
		`CHK(irq, 1'b0)
		rd(8'h14, 32'h1, 32'h1);
		wr(8'h1C, 32'h1);
		repeat (2) @(posedge clk_sys);
		`CHK(irq, 1'b1)
		$display("test alarm done");
		// Every interval code: readback, codes 0 to 2 fire, reserved stay quiet
		for (int c = 0; c < 16; c++) begin
			wr(8'h00, 32'hC080 | (c << 10));
			wr(8'h18, 32'h1);
			// Ten-second code fires once seconds ones reach zero, within 160 cycles
			if (c < 3)
				wait_irq();
			if (c >= 10) begin
				repeat (48) @(posedge clk_sys);
				rd(8'h14, 32'h0, 32'h1);
			end
			rd(8'h00, 32'hC000 | (c << 10), 32'hFF00);
		end
		wr(8'h00, 32'h0);
		$display("test interval codes done");
		// Window pointer walks down and stops at zero
		wr(8'h00, 32'h0200);
		pstrb <= 4'h1;
		wr(8'h0C, 32'h1234);
		pstrb <= 4'hF;
		rd(8'h00, 32'h0200, 32'hFFFF);
		wr(8'h0C, 32'h1234);
		rd(8'h00, 32'h0100, 32'hFFFF);
		wr(8'h00, 32'h0200);
		rd(8'h0C, 32'h1234, 32'hFFFF);
		rd(8'h0C, 32'h0, 32'hFFFF_FFFF);
		rd(8'h0C, 32'h0, 32'hFFFF_FFFF);
		rd(8'h00, 32'h0, 32'hFFFF);
		wr(8'h00, 32'h0300);
		rd(8'h0C, 32'h0, 32'hFFFF_FFFF);
		$display("test window pointer done");
		wrap_up();
	end
endmodule : rtcal_top_tb_top
`default_nettype wire
